// ===== rtl/dbg_port_regs.svh
// Timing counts, key bytes and field constants for the debug port front end.
`ifndef DBG_PORT_REGS_SVH
`define DBG_PORT_REGS_SVH

`define CLK_PERIOD_NS      10
`define RESET_WAIT_MS      5
`define RESET_WAIT_CYCLES  ((`RESET_WAIT_MS * 1000000) / `CLK_PERIOD_NS)
`define RATE_BYTE          8'h80
`define KEY_BYTE0          8'heb
`define KEY_BYTE1          8'h5a
`define KEY_BYTE2          8'h70
`define KEY_BYTE3          8'hcd
`define BREAK_OPCODE       8'h00
`define CTRL_DEBUG_ENTER   8'h80
`define RUNTIME_MAX        16'hffff
`define RATE_LOW_BITS      8
`define RATE_TIMEOUT       20'hfffff

`endif

// ===== rtl/dbg_port_pkg.sv
// Types shared by the debug port front end.
package dbg_port_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;

    typedef enum logic [2:0] {
        UNL_WAIT_RESET,
        UNL_RATE,
        UNL_KEY0,
        UNL_KEY1,
        UNL_KEY2,
        UNL_KEY3,
        UNL_DONE,
        UNL_FAIL
    } unlock_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
    } decode_t;

endpackage

// ===== rtl/dbg_serial_rx.sv
// Serial byte receiver for the debug link with rate measurement.
`timescale 1ns/10ps
`include "dbg_port_regs.svh"

module dbg_serial_rx (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_line,
    input  wire logic              i_measure,
    output dbg_port_pkg::rx_byte_t o_byte,
    output logic [19:0]            o_bit_period
);

    dbg_port_pkg::rx_state_t state_q;
    logic [19:0]             period_q;
    logic [19:0]             cnt_q;
    logic [2:0]              bit_q;
    logic [7:0]              shift_q;
    logic                    line_q;
    logic                    measuring_q;
    dbg_port_pkg::rx_byte_t  byte_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            line_q <= 1'b1;
        end else begin
            line_q <= i_line;
        end
    end

    // ----------------------------------------------------------------
    // Receiver. In measure mode the start bit plus seven zero bits of
    // the rate byte form one low stretch whose length is eight periods.
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_q     <= dbg_port_pkg::RX_IDLE;
            period_q    <= 20'h00000;
            cnt_q       <= 20'h00000;
            bit_q       <= 3'h0;
            shift_q     <= 8'h00;
            measuring_q <= 1'b0;
            byte_q      <= '0;
        end else begin
            byte_q.valid <= 1'b0;
            case (state_q)
                dbg_port_pkg::RX_IDLE: begin
                    cnt_q <= 20'h00000;
                    if (!line_q) begin
                        measuring_q <= i_measure;
                        state_q     <= dbg_port_pkg::RX_START;
                    end
                end
                dbg_port_pkg::RX_START: begin
                    cnt_q <= cnt_q + 20'h00001;
                    if (measuring_q) begin
                        if (line_q) begin
                            period_q     <= cnt_q >> 3;
                            byte_q.valid <= 1'b1;
                            byte_q.data  <= `RATE_BYTE;
                            state_q      <= dbg_port_pkg::RX_STOP;
                            cnt_q        <= 20'h00000;
                        end else if (cnt_q == `RATE_TIMEOUT) begin
                            state_q <= dbg_port_pkg::RX_IDLE;
                        end
                    end else if (cnt_q == (period_q >> 1)) begin
                        cnt_q   <= 20'h00000;
                        bit_q   <= 3'h0;
                        state_q <= line_q ? dbg_port_pkg::RX_IDLE : dbg_port_pkg::RX_DATA;
                    end
                end
                dbg_port_pkg::RX_DATA: begin
                    cnt_q <= cnt_q + 20'h00001;
                    if (cnt_q == period_q) begin
                        cnt_q   <= 20'h00000;
                        shift_q <= {line_q, shift_q[7:1]};
                        bit_q   <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_q <= dbg_port_pkg::RX_STOP;
                            byte_q.valid <= 1'b1;
                            byte_q.data  <= {line_q, shift_q[7:1]};
                        end
                    end
                end
                default: begin
                    if (line_q) begin
                        state_q <= dbg_port_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_byte       = byte_q;
    assign o_bit_period = period_q;

endmodule // dbg_serial_rx

// ===== rtl/debug_port_unlock_breakpoint.sv
// Debug pin unlock, breakpoint handling and runtime counter.
`timescale 1ns/10ps
`include "dbg_port_regs.svh"

module debug_port_unlock_breakpoint #(
    parameter int RESET_WAIT = `RESET_WAIT_CYCLES
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_n,
    input  wire logic           i_reset_shared_pin,
    input  wire logic           i_debug_shared_pin,
    input  dbg_port_pkg::decode_t i_decode,
    input  wire logic           i_break_enable,
    input  wire logic           i_ctrl_write,
    input  wire logic [7:0]     i_ctrl_data,
    input  wire logic           i_debug_exit,
    input  wire logic           i_measure_request,
    output logic                o_debug_link_en,
    output logic                o_gpio_mode,
    output logic                o_breakpoint_instruction,
    output logic                o_break_nop,
    output logic                o_debug_mode,
    output logic                o_core_idle,
    output logic [15:0]         o_runtime_count,
    output logic [7:0]          o_rx_data,
    output logic                o_rx_valid
);

    // ----------------------------------------------------------------
    // Pin synchronisers.
    // ----------------------------------------------------------------
    logic                       rst_pin_meta_q;
    logic                       rst_pin_q;
    logic                       dbg_meta_q;
    logic                       dbg_sync_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rst_pin_meta_q <= 1'b1;
            rst_pin_q      <= 1'b1;
            dbg_meta_q     <= 1'b1;
            dbg_sync_q     <= 1'b1;
        end else begin
            rst_pin_meta_q <= i_reset_shared_pin;
            rst_pin_q      <= rst_pin_meta_q;
            dbg_meta_q     <= i_debug_shared_pin;
            dbg_sync_q     <= dbg_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Receiver shared by unlock and later rate measurements.
    // ----------------------------------------------------------------
    dbg_port_pkg::unlock_state_t unl_q;
    dbg_port_pkg::rx_byte_t      rx_byte;
    logic                        rx_measure;
    logic                        rearm_q;

    assign rx_measure = (unl_q == dbg_port_pkg::UNL_RATE) || rearm_q;

    dbg_serial_rx u_rx (
        .i_ref_clk    (i_ref_clk),
        .i_rst_n      (i_rst_n),
        .i_line       (dbg_sync_q),
        .i_measure    (rx_measure),
        .o_byte       (rx_byte),
        .o_bit_period ()
    );

    // ----------------------------------------------------------------
    // Unlock sequence, only advanced while the reset pin is held low.
    // ----------------------------------------------------------------
    logic [31:0]                 wait_q;
    logic                        unlocked_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            unl_q  <= dbg_port_pkg::UNL_WAIT_RESET;
            wait_q <= 32'h00000000;
        end else if (rst_pin_q) begin
            if (unl_q != dbg_port_pkg::UNL_DONE) begin
                unl_q <= dbg_port_pkg::UNL_WAIT_RESET;
            end
            wait_q <= 32'h00000000;
        end else begin
            case (unl_q)
                dbg_port_pkg::UNL_WAIT_RESET: begin
                    if (wait_q >= 32'(RESET_WAIT - 1)) begin
                        unl_q <= dbg_port_pkg::UNL_RATE;
                    end else begin
                        wait_q <= wait_q + 32'h00000001;
                    end
                end
                dbg_port_pkg::UNL_RATE: begin
                    if (rx_byte.valid) begin
                        unl_q <= dbg_port_pkg::UNL_KEY0;
                    end
                end
                dbg_port_pkg::UNL_KEY0: begin
                    if (rx_byte.valid) begin
                        unl_q <= (rx_byte.data == `KEY_BYTE0) ? dbg_port_pkg::UNL_KEY1
                                                              : dbg_port_pkg::UNL_FAIL;
                    end
                end
                dbg_port_pkg::UNL_KEY1: begin
                    if (rx_byte.valid) begin
                        unl_q <= (rx_byte.data == `KEY_BYTE1) ? dbg_port_pkg::UNL_KEY2
                                                              : dbg_port_pkg::UNL_FAIL;
                    end
                end
                dbg_port_pkg::UNL_KEY2: begin
                    if (rx_byte.valid) begin
                        unl_q <= (rx_byte.data == `KEY_BYTE2) ? dbg_port_pkg::UNL_KEY3
                                                              : dbg_port_pkg::UNL_FAIL;
                    end
                end
                dbg_port_pkg::UNL_KEY3: begin
                    if (rx_byte.valid) begin
                        unl_q <= (rx_byte.data == `KEY_BYTE3) ? dbg_port_pkg::UNL_DONE
                                                              : dbg_port_pkg::UNL_FAIL;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Debug link is granted only once reset is released after a full key.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            unlocked_q <= 1'b0;
        end else begin
            unlocked_q <= unlocked_q || ((unl_q == dbg_port_pkg::UNL_DONE) && rst_pin_q);
        end
    end

    // ----------------------------------------------------------------
    // Rate re-measure and debug mode control.
    // ----------------------------------------------------------------
    logic                        debug_q;
    logic                        rate_ok_q;
    logic                        brk_hit;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rearm_q   <= 1'b0;
            rate_ok_q <= 1'b0;
        end else if (!unlocked_q) begin
            rearm_q   <= 1'b0;
            rate_ok_q <= 1'b0;
        end else if (i_measure_request) begin
            rearm_q   <= 1'b1;
            rate_ok_q <= 1'b0;
        end else if (rearm_q && rx_byte.valid) begin
            rearm_q   <= 1'b0;
            rate_ok_q <= 1'b1;
        end
    end

    assign brk_hit = i_decode.valid && (i_decode.opcode == `BREAK_OPCODE);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            debug_q <= 1'b0;
        end else if (brk_hit && i_break_enable) begin
            debug_q <= 1'b1;
        end else if (rate_ok_q && i_ctrl_write && (i_ctrl_data == `CTRL_DEBUG_ENTER)) begin
            debug_q <= 1'b1;
        end else if (i_debug_exit) begin
            debug_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Runtime counter.
    // ----------------------------------------------------------------
    logic [15:0]                 runtime_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            runtime_q <= 16'h0000;
        end else if (debug_q && i_debug_exit) begin
            runtime_q <= 16'h0000;
        end else if (!debug_q && (runtime_q != `RUNTIME_MAX)) begin
            runtime_q <= runtime_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    logic                        brk_q;
    logic                        nop_q;
    logic [7:0]                  rx_data_q;
    logic                        rx_valid_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            brk_q      <= 1'b0;
            nop_q      <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            brk_q      <= brk_hit;
            nop_q      <= brk_hit && !i_break_enable;
            rx_valid_q <= rx_byte.valid && unlocked_q;
            if (rx_byte.valid && unlocked_q) begin
                rx_data_q <= rx_byte.data;
            end
        end
    end

    assign o_debug_link_en          = unlocked_q;
    assign o_gpio_mode              = !unlocked_q;
    assign o_breakpoint_instruction = brk_q;
    assign o_break_nop              = nop_q;
    assign o_debug_mode             = debug_q;
    assign o_core_idle              = debug_q;
    assign o_runtime_count          = runtime_q;
    assign o_rx_data                = rx_data_q;
    assign o_rx_valid               = rx_valid_q;

endmodule // debug_port_unlock_breakpoint

// ===== test/dbg_host_model.sv
// Debug host model: drives the shared reset pin and the serial debug line.
`timescale 1ns/10ps

module dbg_host_model #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic i_ref_clk,
    output logic      o_reset_pin,
    output logic      o_line
);
    initial begin
        o_reset_pin = 1'b1;
        o_line      = 1'b1;
    end

    // Start bit, eight data bits LSB first, stop bit, then two idle bit times.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line = fr[i];
            repeat (BIT_CLKS) @(negedge i_ref_clk);
        end
        repeat (2 * BIT_CLKS) @(negedge i_ref_clk);
    endtask

    task automatic unlock(input logic [7:0] last, input int wait_clks);
        o_reset_pin = 1'b0;
        repeat (wait_clks) @(negedge i_ref_clk);
        send_byte(8'h80);
        send_byte(8'heb);
        send_byte(8'h5a);
        send_byte(8'h70);
        send_byte(last);
        o_reset_pin = 1'b1;
    endtask
endmodule // dbg_host_model

// ===== test/debug_port_unlock_breakpoint_assertions.sv
// Checker for the debug port pin mode, breakpoint and runtime counter.
`timescale 1ns/10ps

module debug_port_unlock_breakpoint_assertions #(
    parameter int RESET_WAIT = 500000
) (
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst_n,
    input wire logic                  i_reset_shared_pin,
    input wire dbg_port_pkg::decode_t i_decode,
    input wire logic                  i_break_enable,
    input wire logic                  i_debug_exit,
    input wire logic                  o_debug_link_en,
    input wire logic                  o_gpio_mode,
    input wire logic                  o_breakpoint_instruction,
    input wire logic                  o_break_nop,
    input wire logic                  o_debug_mode,
    input wire logic                  o_core_idle,
    input wire logic [15:0]           o_runtime_count
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_brk;
        i_decode.valid && i_decode.opcode == 8'h00;
    endsequence
    sequence s_exit;
        o_debug_mode && i_debug_exit && !i_decode.valid;
    endsequence

    a_gpio_inverse: assert property (o_gpio_mode == !o_debug_link_en)
        else $error("gpio mode not inverse of link enable");
    a_link_after_release: assert property ($rose(o_debug_link_en) |-> $past(i_reset_shared_pin))
        else $error("link enabled while reset pin held");
    a_link_stays_on: assert property (o_debug_link_en |=> o_debug_link_en)
        else $error("link enable dropped");
    a_brk_pulse: assert property (s_brk |=> o_breakpoint_instruction)
        else $error("breakpoint opcode not signalled");
    a_brk_cause: assert property (o_breakpoint_instruction |->
        $past(i_decode.valid) && $past(i_decode.opcode) == 8'h00)
        else $error("breakpoint signal without opcode");
    a_brk_enter: assert property (s_brk ##0 i_break_enable |=> o_debug_mode && o_core_idle)
        else $error("enabled breakpoint did not enter debug");
    a_idle_matches: assert property (o_core_idle == o_debug_mode)
        else $error("core idle differs from debug mode");
    a_brk_ignored: assert property (s_brk ##0 !i_break_enable |=>
        o_break_nop && !$rose(o_debug_mode))
        else $error("disabled breakpoint not ignored");
    a_count_runs: assert property (!o_debug_mode && o_runtime_count != 16'hffff |=>
        o_debug_mode || o_runtime_count == $past(o_runtime_count) + 16'h1)
        else $error("runtime count did not advance");
    a_count_frozen: assert property (o_debug_mode && $past(o_debug_mode) |->
        $stable(o_runtime_count))
        else $error("runtime count moved in debug");
    a_count_saturates: assert property (o_runtime_count == 16'hffff && !o_debug_mode &&
        !i_debug_exit |=> o_runtime_count == 16'hffff)
        else $error("runtime count wrapped");
    a_exit_clears: assert property (s_exit |=> !o_debug_mode && o_runtime_count == 16'h0000)
        else $error("exit did not restart count");
endmodule // debug_port_unlock_breakpoint_assertions

bind debug_port_unlock_breakpoint debug_port_unlock_breakpoint_assertions #(
    .RESET_WAIT(RESET_WAIT)
) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reset_shared_pin(i_reset_shared_pin),
    .i_decode(i_decode), .i_break_enable(i_break_enable), .i_debug_exit(i_debug_exit),
    .o_debug_link_en(o_debug_link_en), .o_gpio_mode(o_gpio_mode),
    .o_breakpoint_instruction(o_breakpoint_instruction), .o_break_nop(o_break_nop),
    .o_debug_mode(o_debug_mode), .o_core_idle(o_core_idle), .o_runtime_count(o_runtime_count)
);

// ===== test/tb_debug_port_unlock_breakpoint.sv
// Testbench for the debug port unlock, breakpoint and runtime counter block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb_debug_port_unlock_breakpoint;
    localparam int WAIT = 20;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  reset_pin, line, brk_en, ctrl_wr, exit_p, meas, link, gpio;
    logic                  breakpoint_instruction, nop, dmode, idle, rx_v;
    logic [7:0]            ctrl_d, rx_d, rx_last;
    logic [15:0]           cnt, c1;
    dbg_port_pkg::decode_t dec = '0;
    int                    mismatches = 0;
    int                    n_compared = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (rx_v === 1'b1) rx_last <= rx_d;

    dbg_host_model #(.BIT_CLKS(16)) host (.i_ref_clk(clk), .o_reset_pin(reset_pin), .o_line(line));
    debug_port_unlock_breakpoint #(.RESET_WAIT(WAIT)) dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_reset_shared_pin(reset_pin),
        .i_debug_shared_pin(line), .i_decode(dec), .i_break_enable(brk_en),
        .i_ctrl_write(ctrl_wr), .i_ctrl_data(ctrl_d), .i_debug_exit(exit_p),
        .i_measure_request(meas), .o_debug_link_en(link), .o_gpio_mode(gpio),
        .o_breakpoint_instruction(breakpoint_instruction), .o_break_nop(nop), .o_debug_mode(dmode),
        .o_core_idle(idle), .o_runtime_count(cnt), .o_rx_data(rx_d), .o_rx_valid(rx_v));

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task pulse(input logic [7:0] op);
        @(negedge clk);
        dec = '{1'b1, op};
        @(negedge clk);
        dec = '0;
    endtask

    task t_break_off;
        brk_en = 1'b0;
        pulse(8'h00);
        `CHK("brk", 1'b1, breakpoint_instruction)
        `CHK("nop", 1'b1, nop)
        `CHK("dmode", 1'b0, dmode)
        pulse(8'h3c);
        `CHK("brk other", 1'b0, breakpoint_instruction)
    endtask

    task t_break_on;
        brk_en = 1'b1;
        pulse(8'h00);
        `CHK("dmode", 1'b1, dmode)
        `CHK("idle", 1'b1, idle)
        `CHK("nop", 1'b0, nop)
        c1 = cnt;
        repeat (5) @(negedge clk);
        `CHK("frozen", c1, cnt)
        exit_p = 1'b1;
        @(negedge clk);
        exit_p = 1'b0;
        `CHK("restart", 16'h0000, cnt)
        repeat (10) @(negedge clk);
        `CHK("counting", 16'h000a, cnt)
    endtask

    task t_saturate;
        repeat (65540) @(negedge clk);
        `CHK("sat", 16'hffff, cnt)
        repeat (3) @(negedge clk);
        `CHK("held", 16'hffff, cnt)
    endtask

    task t_unlock;
        host.unlock(8'hcc, WAIT + 10);
        repeat (10) @(negedge clk);
        `CHK("bad key link", 1'b0, link)
        `CHK("bad key gpio", 1'b1, gpio)
        host.unlock(8'hcd, WAIT + 10);
        repeat (10) @(negedge clk);
        `CHK("link", 1'b1, link)
        `CHK("gpio", 1'b0, gpio)
        host.send_byte(8'ha5);
        `CHK("rx", 8'ha5, rx_last)
        meas = 1'b1;
        @(negedge clk);
        meas = 1'b0;
        host.send_byte(8'h80);
        ctrl_d = 8'h80;
        ctrl_wr = 1'b1;
        @(negedge clk);
        ctrl_wr = 1'b0;
        `CHK("cmd dmode", 1'b1, dmode)
    endtask

    initial begin
        {brk_en, ctrl_wr, exit_p, meas, ctrl_d} = '0;
        repeat (10) @(negedge clk);
        `CHK("rst gpio", 1'b1, gpio)
        `CHK("rst count", 16'h0000, cnt)
        rst_n = 1'b1;
        t_break_off();
        t_break_on();
        t_saturate();
        t_unlock();
        summarize();
    end

    initial begin
        #900_000;
        mismatches++;
        summarize();
    end
endmodule // tb_debug_port_unlock_breakpoint
